// File: bench/cpsp_assertions.sv
// Purpose: port checks for the present-state port
// Assumes: zero-wait apb slave
// Notes: removal bounds allow for sync and detect fsm lag
`timescale 1ns/100ps
`default_nettype none
module cpsp_assertions (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic [11:0] paddr_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        card_detect_pin_n_i,
    input wire logic        cmd_oe_o,
    input wire logic [3:0]  dat_oe_o,
    input wire logic        card_clk_o,
    input wire logic        bus_power_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ready_answer: assert property (psel_i && penable_i |-> pready_o)
        else $error("no ready in access phase");
    a_ready_access: assert property (pready_o |-> psel_i && penable_i)
        else $error("ready outside access phase");
    a_ready_once: assert property (pready_o |=> !pready_o)
        else $error("ready longer than one cycle");
    a_port_no_err: assert property (pready_o && paddr_i[11:3] == 9'h004 |-> !pslverr_o)
        else $error("error on a mapped word");
    a_cmd_release: assert property ($rose(card_detect_pin_n_i) |-> ##[1:6] !cmd_oe_o)
        else $error("cmd still driven after removal");
    a_dat_release: assert property ($rose(card_detect_pin_n_i) |-> ##[1:6] dat_oe_o == 4'h0)
        else $error("dat still driven after removal");
    a_power_cut: assert property ($rose(card_detect_pin_n_i) && bus_power_o
        && (card_clk_o || $past(card_clk_o)) |-> ##[1:6] !bus_power_o)
        else $error("power kept after removal");
    a_clock_stop: assert property ($rose(card_detect_pin_n_i) && bus_power_o
        |-> ##[1:8] !card_clk_o [*4])
        else $error("card clock kept after removal");
    cover property (psel_i && penable_i && paddr_i == 12'h020);
    cover property (pslverr_o);
    cover property ($rose(card_detect_pin_n_i) && bus_power_o);
endmodule // cpsp_assertions
`default_nettype wire

// File: bench/cpsp_card_model.sv
// Purpose: card in the socket, pins and pulled-up bus lines
// Assumes: host drives a line only while its enable is high
// Notes: released lines read high through the pull-ups, except dat lines that a present card pulls low
`timescale 1ns/100ps
`default_nettype none
module cpsp_card_model (
    input wire logic       clk_i,
    input wire logic       present_i,
    input wire logic       protect_i,
    input wire logic [3:0] pull_low_i,
    input wire logic       host_cmd_i,
    input wire logic       host_cmd_oe_i,
    input wire logic [3:0] host_dat_i,
    input wire logic [3:0] host_dat_oe_i,
    output logic           cd_n_o,
    output logic           wp_n_o,
    output logic           cmd_line_o,
    output logic [3:0]     dat_line_o
);
    logic in_r = 1'b0;
    always @(posedge clk_i) begin
        in_r   <= present_i;
        cd_n_o <= !present_i;
        wp_n_o <= !protect_i;
    end
    initial begin
        cd_n_o = 1'b1;
        wp_n_o = 1'b1;
    end
    // a busy card holds its dat lines low until removed
    assign cmd_line_o = host_cmd_oe_i ? host_cmd_i : 1'b1;
    assign dat_line_o = (host_dat_oe_i & host_dat_i) | (~host_dat_oe_i & ~(pull_low_i & {4{in_r}}));
endmodule // cpsp_card_model
`default_nettype wire

// File: bench/tb_card_present_state_port.sv
// Purpose: register-level test of the present-state port
// Assumes: debounce shortened to 8 cycles
// Notes: low status bits 11..0 lie outside this block and are masked
`timescale 1ns/100ps
`default_nettype none
module tb_card_present_state_port;
    logic        clk_i, rst_i, psel, penable, pwrite, present, protect, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, cd_n, wp_n, cmd_line, cmd_out, cmd_oe, card_clk, bus_power, irq;
    wire  [3:0]  dat_line, dat_out, dat_oe;
    int          n_fail, comparisons, cycles;
    localparam logic [31:0] M = 32'hffff_f000;
    cpsp_present_state #(.DEBOUNCE_CYC(8)) i_cpsp_present_state (.clk_i(clk_i), .rst_i(rst_i),
        .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .card_detect_pin_n_i(cd_n),
        .write_protect_pin_n_i(wp_n), .cmd_i(cmd_line), .cmd_o(cmd_out), .cmd_oe_o(cmd_oe),
        .dat_i(dat_line), .dat_o(dat_out), .dat_oe_o(dat_oe), .card_clk_o(card_clk),
        .bus_power_o(bus_power), .irq_o(irq));
    cpsp_card_model i_cpsp_card_model (.clk_i(clk_i), .present_i(present), .protect_i(protect),
        .pull_low_i(4'h1), .host_cmd_i(cmd_out), .host_cmd_oe_i(cmd_oe), .host_dat_i(dat_out),
        .host_dat_oe_i(dat_oe), .cd_n_o(cd_n), .wp_n_o(wp_n), .cmd_line_o(cmd_line),
        .dat_line_o(dat_line));
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    function automatic logic [31:0] ps(input logic [3:0] d, input logic w, c, s, n);
        return {7'h00, 1'b1, d, w, c, s, n, 16'h0000};
    endfunction
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        // look at the settled answer mid-cycle, complete at the edge that follows it
        do begin
            @(negedge clk_i);
            rd = prdata;
            err = pslverr;
        end while (pready !== 1'b1);
        @(posedge clk_i);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // the whole sequence needs well under 1000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_fail++;
            wrap_up;
        end
    end
    initial begin
        {psel, penable, pwrite, present, protect, err} = 6'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        {n_fail, comparisons, cycles} = 0;
        rst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        repeat (20) @(posedge clk_i);
        apb(0, 12'h024, 0);
        chk("no card", rd & M, ps(4'hf, 1, 0, 1, 0));
        apb(1, 12'h024, 32'hffff_ffff);
        apb(0, 12'h024, 0);
        chk("ro state", rd & M, ps(4'hf, 1, 0, 1, 0));
        for (int i = 0; i < 4; i++) apb(1, 12'h020, 32'h1234_5670 + i);
        for (int i = 0; i < 4; i++) begin
            apb(0, 12'h020, 0);
            chk("buffer", rd, 32'h1234_5670 + i);
        end
        apb(0, 12'h040, 0);
        chk("unmapped", {31'h0, err}, 32'h1);
        apb(1, 12'h034, 3);
        present <= 1'b1;
        protect <= 1'b1;
        repeat (4) @(posedge clk_i);
        apb(0, 12'h024, 0);
        chk("debounce", rd & M, ps(4'he, 0, 1, 0, 0));
        repeat (20) @(posedge clk_i);
        apb(0, 12'h024, 0);
        chk("inserted", rd & M, ps(4'he, 0, 1, 1, 1));
        chk("irq in", {31'h0, irq}, 32'h1);
        apb(0, 12'h030, 0);
        chk("stat in", rd & 32'h3, 32'h1);
        apb(1, 12'h030, 1);
        repeat (2) @(posedge clk_i);
        chk("irq clr", {31'h0, irq}, 32'h0);
        apb(1, 12'h028, 8);
        repeat (2) @(posedge clk_i);
        apb(0, 12'h024, 0);
        chk("soft rst", rd & M, ps(4'he, 0, 1, 1, 1));
        apb(1, 12'h028, 7);
        repeat (4) @(posedge clk_i);
        chk("driving", {26'h0, bus_power, cmd_oe, dat_oe}, 32'h3f);
        present <= 1'b0;
        protect <= 1'b0;
        repeat (10) @(posedge clk_i);
        chk("released", {26'h0, bus_power, cmd_oe, dat_oe}, 32'h0);
        apb(0, 12'h028, 0);
        chk("ctrl cut", rd & 32'h7, 32'h0);
        chk("irq mask", {31'h0, irq}, 32'h0);
        apb(0, 12'h030, 0);
        chk("stat out", rd & 32'h3, 32'h2);
        apb(1, 12'h034, 2);
        repeat (2) @(posedge clk_i);
        chk("irq out", {31'h0, irq}, 32'h1);
        apb(1, 12'h028, 8);
        repeat (20) @(posedge clk_i);
        apb(0, 12'h024, 0);
        chk("settled", rd & M, ps(4'hf, 1, 0, 1, 0));
        wrap_up;
    end
endmodule // tb_card_present_state_port
bind cpsp_present_state cpsp_assertions i_cpsp_assertions (.clk_i(clk_i), .rst_i(rst_i),
    .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .card_detect_pin_n_i(card_detect_pin_n_i), .cmd_oe_o(cmd_oe_o),
    .dat_oe_o(dat_oe_o), .card_clk_o(card_clk_o), .bus_power_o(bus_power_o));
`default_nettype wire

// File: common/cpsp_regs.vh
// Purpose: register map and constants of the card present-state port
// Assumes: apb byte addresses, 32-bit aligned words
// Notes: control and interrupt registers sit above the two fixed words
`ifndef CPSP_REGS_VH
`define CPSP_REGS_VH
`define CPSP_ADDR_W          12
`define CPSP_OFF_BUF_DATA    12'h020
`define CPSP_OFF_PRESENT     12'h024
`define CPSP_OFF_CTRL        12'h028
`define CPSP_OFF_INT_STAT    12'h030
`define CPSP_OFF_INT_MASK    12'h034
`define CPSP_BIT_CMD_LVL     24
`define CPSP_BIT_DAT_HI      23
`define CPSP_BIT_DAT_LO      20
`define CPSP_BIT_WP_LVL      19
`define CPSP_BIT_CD_LVL      18
`define CPSP_BIT_STABLE      17
`define CPSP_BIT_INSERTED    16
`define CPSP_CTRL_BUS_PWR    0
`define CPSP_CTRL_CLK_EN     1
`define CPSP_CTRL_DRV_EN     2
`define CPSP_CTRL_SW_RESET   3
`define CPSP_INT_INSERT      0
`define CPSP_INT_REMOVE      1
`define CPSP_DEBOUNCE_NS     1000000
`define CPSP_CLK_NS          25
`define CPSP_BUF_DEPTH       128
`endif

// File: rtl/cpsp_present_state.v
// Purpose: buffer data port, present-state register, card detect debounce
// Assumes: apb slave, zero wait states; socket pins asynchronous
// Notes: card clock is driven as a divided clock from clk_i
//
// Summary of operation
// RQ1: one 32-bit data port word moves one buffer word per access.
// RQ2: present-state register is read only; writes are ignored.
// RQ3: bit 24 returns the sampled cmd line level.
// RQ4: bits 23..20 return sampled dat3 down to dat0.
// RQ5: bit 19 follows write protect pin, 1 means write enabled.
// RQ6: bit 18 is raw inverse of card detect pin, testing only.
// RQ7: bit 17 is 1 when detect level stable, 0 in reset or debouncing.
// RQ8: full software reset leaves stable and inserted bits untouched.
// RQ9: bit 16 is debounced card inserted flag.
// RQ10: inserted rising sets insertion status, falling sets removal status.
// RQ11: removal with power on and clock running clears power and clock enable.
// RQ12: inserted falling releases cmd and dat lines at once.
// RQ13: software should issue full reset after removal is reported.
// RQ14: detection runs whether bus power is on or off.
// RQ15: detect fsm goes reset, debouncing, then inserted or no card.
// RQ16: reserved present-state bits read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "cpsp_regs.vh"
module cpsp_present_state #(
    parameter DEBOUNCE_CYC = (`CPSP_DEBOUNCE_NS + `CPSP_CLK_NS - 1) / `CPSP_CLK_NS,
    parameter BUF_DEPTH    = `CPSP_BUF_DEPTH,
    parameter CLK_DIV      = 4
) (
    input  wire        clk_i,
    input  wire        rst_i,
    input  wire        psel_i,
    input  wire        penable_i,
    input  wire        pwrite_i,
    input  wire [11:0] paddr_i,
    input  wire [31:0] pwdata_i,
    output reg  [31:0] prdata_o,
    output reg         pready_o,
    output reg         pslverr_o,
    input  wire        card_detect_pin_n_i,
    input  wire        write_protect_pin_n_i,
    input  wire        cmd_i,
    output reg         cmd_o,
    output reg         cmd_oe_o,
    input  wire [3:0]  dat_i,
    output reg  [3:0]  dat_o,
    output reg  [3:0]  dat_oe_o,
    output reg         card_clk_o,
    output reg         bus_power_o,
    output reg         irq_o
);
    localparam ST_RESET = 3'h1;
    localparam ST_DEB   = 3'h2;
    localparam ST_STBL  = 3'h4;
    localparam AW       = $clog2(BUF_DEPTH);

    wire [6:0] pins_s;
    cpsp_sync2 #(.W(7), .RST(1'b1)) u_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   ({card_detect_pin_n_i, write_protect_pin_n_i, cmd_i, dat_i}),
        .q_o   (pins_s)
    );
    wire       cd_n_s = pins_s[6];
    wire       wp_n_s = pins_s[5];
    wire       cmd_s  = pins_s[4];
    wire [3:0] dat_s  = pins_s[3:0];

    reg [2:0]  det_state_reg;
    reg [31:0] deb_cnt_reg;
    reg        deb_last_reg;
    reg        inserted_reg;
    reg        stable_reg;
    reg        ctrl_pwr_reg;
    reg        ctrl_clk_reg;
    reg        ctrl_drv_reg;
    reg [1:0]  int_stat_reg;
    reg [1:0]  int_mask_reg;
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [31:0] buf_mem [0:BUF_DEPTH-1];
    reg [15:0] div_cnt_reg;

    wire acc    = psel_i & penable_i;
    wire wr_acc = acc & pwrite_i;
    wire rd_acc = acc & ~pwrite_i;
    wire sw_rst = wr_acc & (paddr_i == `CPSP_OFF_CTRL) & pwdata_i[`CPSP_CTRL_SW_RESET];

    // detect fsm runs with no term on bus power, and no soft reset input
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            det_state_reg <= ST_RESET;
            deb_cnt_reg   <= 32'h0;
            deb_last_reg  <= 1'b1;
            inserted_reg  <= 1'b0;
            stable_reg    <= 1'b0;
        end else begin
            deb_last_reg <= cd_n_s;
            case (det_state_reg)
                ST_RESET: begin
                    det_state_reg <= ST_DEB; // RQ15
                    deb_cnt_reg   <= 32'h0;
                end
                ST_DEB: begin
                    if (cd_n_s != deb_last_reg) begin
                        deb_cnt_reg <= 32'h0;
                    end else if (deb_cnt_reg >= DEBOUNCE_CYC - 1) begin
                        det_state_reg <= ST_STBL; // RQ15
                        stable_reg    <= 1'b1; // RQ7
                        inserted_reg  <= ~cd_n_s; // RQ9
                    end else begin
                        deb_cnt_reg <= deb_cnt_reg + 32'h1;
                    end
                end
                ST_STBL: begin
                    if (cd_n_s != deb_last_reg) begin
                        // any change, removal included, drops back at once
                        det_state_reg <= ST_DEB; // RQ15
                        stable_reg    <= 1'b0; // RQ7
                        inserted_reg  <= 1'b0; // RQ9
                        deb_cnt_reg   <= 32'h0;
                    end
                end
                default: begin
                    det_state_reg <= ST_RESET;
                    stable_reg    <= 1'b0;
                    inserted_reg  <= 1'b0;
                end
            endcase
        end
    end
    // RQ14 RQ8

    reg  ins_d_reg;
    wire ins_rise = inserted_reg & ~ins_d_reg;
    wire ins_fall = ~inserted_reg & ins_d_reg;

    // control and interrupt registers; interrupt status set beats clear
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ins_d_reg    <= 1'b0;
            ctrl_pwr_reg <= 1'b0;
            ctrl_clk_reg <= 1'b0;
            ctrl_drv_reg <= 1'b0;
            int_stat_reg <= 2'h0;
            int_mask_reg <= 2'h0;
        end else begin
            ins_d_reg <= inserted_reg;
            if (sw_rst) begin
                ctrl_pwr_reg <= 1'b0;
                ctrl_clk_reg <= 1'b0;
                ctrl_drv_reg <= 1'b0;
                int_mask_reg <= 2'h0;
            end else if (wr_acc & (paddr_i == `CPSP_OFF_CTRL)) begin
                ctrl_pwr_reg <= pwdata_i[`CPSP_CTRL_BUS_PWR];
                ctrl_clk_reg <= pwdata_i[`CPSP_CTRL_CLK_EN];
                ctrl_drv_reg <= pwdata_i[`CPSP_CTRL_DRV_EN];
            end else if (wr_acc & (paddr_i == `CPSP_OFF_INT_MASK)) begin
                int_mask_reg <= pwdata_i[1:0];
            end
            if (ins_fall & ctrl_pwr_reg & ctrl_clk_reg) begin
                ctrl_pwr_reg <= 1'b0; // RQ11
                ctrl_clk_reg <= 1'b0; // RQ11
            end
            if (ins_fall) begin
                ctrl_drv_reg <= 1'b0; // RQ12
            end
            int_stat_reg <= (sw_rst ? 2'h0 :
                             (wr_acc & (paddr_i == `CPSP_OFF_INT_STAT)) ? (int_stat_reg & ~pwdata_i[1:0]) :
                             int_stat_reg)
                            | {ins_fall, ins_rise}; // RQ10
        end
    end

    // line drive: released one clock after the inserted flag falls
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_o    <= 1'b1;
            cmd_oe_o <= 1'b0;
            dat_o    <= 4'hf;
            dat_oe_o <= 4'h0;
        end else begin
            cmd_o    <= 1'b1;
            dat_o    <= 4'hf;
            cmd_oe_o <= ctrl_drv_reg & inserted_reg & ~ins_fall; // RQ12
            dat_oe_o <= {4{ctrl_drv_reg & inserted_reg & ~ins_fall}}; // RQ12
        end
    end

    // card clock: one-cycle enable from a divider toggles the pin
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            div_cnt_reg <= 16'h0;
            card_clk_o  <= 1'b0;
            bus_power_o <= 1'b0;
            irq_o       <= 1'b0;
        end else begin
            bus_power_o <= ctrl_pwr_reg;
            irq_o       <= |(int_stat_reg & int_mask_reg);
            if (!ctrl_clk_reg) begin
                div_cnt_reg <= 16'h0;
                card_clk_o  <= 1'b0;
            end else if (div_cnt_reg >= CLK_DIV - 1) begin
                div_cnt_reg <= 16'h0;
                card_clk_o  <= ~card_clk_o;
            end else begin
                div_cnt_reg <= div_cnt_reg + 16'h1;
            end
        end
    end

    // buffer words: writes fill, reads drain, one word per access
    always @(posedge clk_i) begin
        if (wr_acc & (paddr_i == `CPSP_OFF_BUF_DATA)) begin
            buf_mem[wr_ptr_reg] <= pwdata_i; // RQ1
        end
    end
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
        end else if (sw_rst) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
        end else begin
            if (wr_acc & (paddr_i == `CPSP_OFF_BUF_DATA)) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1; // RQ1
            end
            if (rd_acc & (paddr_i == `CPSP_OFF_BUF_DATA)) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1; // RQ1
            end
        end
    end

    reg [31:0] present_w;
    always @* begin
        present_w = 32'h0; // RQ16
        present_w[`CPSP_BIT_CMD_LVL]                  = cmd_s; // RQ3
        present_w[`CPSP_BIT_DAT_HI:`CPSP_BIT_DAT_LO]  = dat_s; // RQ4
        present_w[`CPSP_BIT_WP_LVL]                   = wp_n_s; // RQ5
        present_w[`CPSP_BIT_CD_LVL]                   = ~cd_n_s; // RQ6
        present_w[`CPSP_BIT_STABLE]                   = stable_reg; // RQ7
        present_w[`CPSP_BIT_INSERTED]                 = inserted_reg; // RQ9
    end

    // apb: setup cycle's edge registers ready and read data; writes act at the access cycle's edge
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o  <= 32'h0;
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
            if (psel_i & ~penable_i) begin
                pready_o <= 1'b1;
                prdata_o <= 32'h0;
                case (paddr_i)
                    `CPSP_OFF_BUF_DATA: prdata_o <= buf_mem[rd_ptr_reg];
                    `CPSP_OFF_PRESENT:  prdata_o <= present_w; // RQ2
                    `CPSP_OFF_CTRL:     prdata_o <= {29'h0, ctrl_drv_reg, ctrl_clk_reg, ctrl_pwr_reg};
                    `CPSP_OFF_INT_STAT: prdata_o <= {30'h0, int_stat_reg};
                    `CPSP_OFF_INT_MASK: prdata_o <= {30'h0, int_mask_reg};
                    default:            pslverr_o <= 1'b1;
                endcase
            end
        end
    end
endmodule // cpsp_present_state
`default_nettype wire

// File: rtl/cpsp_sync2.v
// Purpose: two flip-flop synchroniser for a bus of pin levels
// Assumes: inputs asynchronous to clk_i
// Notes: first stage feeds only the second
`timescale 1ns/100ps
`default_nettype none
module cpsp_sync2 #(
    parameter W   = 1,
    parameter RST = 1'b0
) (
    input  wire         clk_i,
    input  wire         rst_i,
    input  wire [W-1:0] d_i,
    output reg  [W-1:0] q_o
);
    reg [W-1:0] meta_reg;
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_reg <= {W{RST}};
            q_o      <= {W{RST}};
        end else begin
            meta_reg <= d_i;
            q_o      <= meta_reg;
        end
    end
endmodule // cpsp_sync2
`default_nettype wire
